// ===== verilog/dtmg_top.sv
// Tone generator control: register file on AXI4-Lite, code validator,
// generator clock tick, two tone paths and the mixed and pacifier outputs.
// Assumes i_stop is driven by logic on i_clock, so it is not synchronised.
//
// How it works
// - Low five pitch bits set each path's tone frequency.
// - Codes 00-03 legal only for row, 10-13 only for column.
// - Any illegal pitch code disables every tone output.
// - Illegal code: pacifier high, mixed output at mid level when enabled.
// - Melody codes 04-0F and 14-1F are legal in either register.
// - Each code yields its tabulated frequency within listed deviation.
// - Control holds mode 7:6, row 5, column 4, enable 3; 2:0 zero.
// - Mode 00 sine, 01 square one, 10 square two, 11 square three.
// - Pacifier idles high, carries row square only in modes two and three.
// - Sine mode mixes both sines; square one and two mix both squares.
// - Square three mixes column square only, row square goes to pacifier.
// - Mixed output disabled while output enable is clear, also after reset.
// - Enable set with both paths off gives steady half level.
// - Stop holds pacifier high and mixed output disabled.
// - Both paths off holds all dividers and scanners in reset.
// - An enabled legal path starts from reset; paths act independently.
// - Divider reset is time step zero; scanner reset addresses dc level.
// - Each path runs only while its own enable is set.
// - Each path divides the generator clock by its code's ratio.
// - Sample pulse steps a 28-state scanner over six-bit sine entries.
// - Square modes pass only the table's top bit, same phase.
// - Pacifier comes from the row path's top table bit, unfiltered.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module dtmg_top
	import dtmg_pkg::*;
(
	input  wire logic        i_clock,
	input  wire logic        i_rst_n,
	input  wire logic        i_stop,
	input  wire logic [7:0]  i_s_axi_awaddr,
	input  wire logic        i_s_axi_awvalid,
	output logic             o_s_axi_awready,
	input  wire logic [31:0] i_s_axi_wdata,
	input  wire logic [3:0]  i_s_axi_wstrb,
	input  wire logic        i_s_axi_wvalid,
	output logic             o_s_axi_wready,
	output logic [1:0]       o_s_axi_bresp,
	output logic             o_s_axi_bvalid,
	input  wire logic        i_s_axi_bready,
	input  wire logic [7:0]  i_s_axi_araddr,
	input  wire logic        i_s_axi_arvalid,
	output logic             o_s_axi_arready,
	output logic [31:0]      o_s_axi_rdata,
	output logic [1:0]       o_s_axi_rresp,
	output logic             o_s_axi_rvalid,
	input  wire logic        i_s_axi_rready,
	output logic [6:0]       o_mixed_tone_out,
	output logic             o_mixed_tone_oe,
	output logic             o_pacifier_out
);

	typedef struct packed {
		logic [4:0] row_pitch_reg;
		logic [4:0] column_pitch_reg;
		logic [4:0] tone_ctrl_reg;
		dtmg_wr_e   wr_state;
		logic       aw_held;
		logic [5:0] aw_idx;
		logic       w_held;
		logic [7:0] wdata;
		logic       wlane0;
		logic [1:0] bresp;
		dtmg_rd_e   rd_state;
		logic [7:0] rdata;
		logic [1:0] rresp;
		logic [11:0] acc;
		logic       gen_tick;
		logic [6:0] mixed;
		logic       mixed_oe;
		logic       pacifier;
	} dtmg_top_s;

	dtmg_top_s s_reg;
	dtmg_top_s s_next;

	dtmg_path_if row_if ();
	dtmg_path_if col_if ();

	// Divider ratios are round(generator clock / (28 * output frequency)).
	function automatic logic [6:0] pitch_ratio(input logic [4:0] code);
		logic [6:0] r;
		r = 7'h5C;
		case (code)
			5'h00: r = 7'h5C;
			5'h01: r = 7'h53;
			5'h02: r = 7'h4B;
			5'h03: r = 7'h44;
			5'h04: r = 7'h67;
			5'h05: r = 7'h61;
			5'h06: r = 7'h5C;
			5'h07: r = 7'h56;
			5'h08: r = 7'h52;
			5'h09: r = 7'h4D;
			5'h0A: r = 7'h49;
			5'h0B: r = 7'h45;
			5'h0C: r = 7'h41;
			5'h0D: r = 7'h3D;
			5'h0E: r = 7'h3A;
			5'h0F: r = 7'h36;
			5'h10: r = 7'h35;
			5'h11: r = 7'h30;
			5'h12: r = 7'h2B;
			5'h13: r = 7'h27;
			5'h14: r = 7'h33;
			5'h15: r = 7'h30;
			5'h16: r = 7'h2E;
			5'h17: r = 7'h2B;
			5'h18: r = 7'h29;
			5'h19: r = 7'h26;
			5'h1A: r = 7'h24;
			5'h1B: r = 7'h22;
			5'h1C: r = 7'h20;
			5'h1D: r = 7'h1F;
			5'h1E: r = 7'h1D;
			5'h1F: r = 7'h1B;
			default: r = 7'h5C;
		endcase
		return r;
	endfunction : pitch_ratio

	// Dial codes belong to one register only; melody codes suit both.
	function automatic logic code_legal(input logic [4:0] code, input logic is_row);
		logic ok;
		ok = 1'b1;
		if (is_row && code[4:2] == 3'h4) begin
			ok = 1'b0;
		end else if (!is_row && code[4:2] == 3'h0) begin
			ok = 1'b0;
		end
		return ok;
	endfunction : code_legal

	logic [1:0] mode;
	logic       row_on;
	logic       col_on;
	logic       out_en;
	logic       row_legal;
	logic       col_legal;
	logic       illegal;
	logic       wr_go;
	logic [12:0] acc_sum;

	always_comb begin
		mode    = {s_reg.tone_ctrl_reg[WAVE_HI_POS], s_reg.tone_ctrl_reg[WAVE_LO_POS]};
		row_on  = s_reg.tone_ctrl_reg[ROW_ON_POS];
		col_on  = s_reg.tone_ctrl_reg[COL_ON_POS];
		out_en  = s_reg.tone_ctrl_reg[OUT_EN_POS];
		row_legal = code_legal(s_reg.row_pitch_reg, 1'b1);
		col_legal = code_legal(s_reg.column_pitch_reg, 1'b0);
		illegal = !row_legal || !col_legal;
	end

	assign row_if.run      = row_on && row_legal && !i_stop;
	assign col_if.run      = col_on && col_legal && !i_stop;
	assign row_if.square   = mode != MODE_SINE;
	assign col_if.square   = mode != MODE_SINE;
	assign row_if.gen_tick = s_reg.gen_tick;
	assign col_if.gen_tick = s_reg.gen_tick;
	assign row_if.ratio    = pitch_ratio(s_reg.row_pitch_reg);
	assign col_if.ratio    = pitch_ratio(s_reg.column_pitch_reg);

	assign o_s_axi_awready = s_reg.wr_state == WR_IDLE && !s_reg.aw_held;
	assign o_s_axi_wready  = s_reg.wr_state == WR_IDLE && !s_reg.w_held;
	assign o_s_axi_bvalid  = s_reg.wr_state == WR_RESP;
	assign o_s_axi_bresp   = s_reg.bresp;
	assign o_s_axi_arready = s_reg.rd_state == RD_IDLE;
	assign o_s_axi_rvalid  = s_reg.rd_state == RD_DATA;
	assign o_s_axi_rdata   = {24'h000000, s_reg.rdata};
	assign o_s_axi_rresp   = s_reg.rresp;
	assign o_mixed_tone_out = s_reg.mixed;
	assign o_mixed_tone_oe  = s_reg.mixed_oe;
	assign o_pacifier_out   = s_reg.pacifier;

	always_comb begin
		s_next  = s_reg;
		wr_go   = s_reg.wr_state == WR_IDLE && s_reg.aw_held && s_reg.w_held;
		acc_sum = {1'b0, s_reg.acc} + {1'b0, ACC_STEP};

		// Address and data are taken independently and joined before the write.
		if (i_s_axi_awvalid && o_s_axi_awready) begin
			s_next.aw_held = 1'b1;
			s_next.aw_idx  = i_s_axi_awaddr[7:2];
		end
		if (i_s_axi_wvalid && o_s_axi_wready) begin
			s_next.w_held = 1'b1;
			s_next.wdata  = i_s_axi_wdata[7:0];
			s_next.wlane0 = i_s_axi_wstrb[0];
		end
		if (wr_go) begin
			s_next.aw_held  = 1'b0;
			s_next.w_held   = 1'b0;
			s_next.wr_state = WR_RESP;
			s_next.bresp    = RESP_OKAY;
			case (s_reg.aw_idx)
				ROW_PITCH_IDX: begin
					if (s_reg.wlane0) begin
						s_next.row_pitch_reg = s_reg.wdata[4:0];
					end
				end
				COL_PITCH_IDX: begin
					if (s_reg.wlane0) begin
						s_next.column_pitch_reg = s_reg.wdata[4:0];
					end
				end
				TONE_CTRL_IDX: begin
					if (s_reg.wlane0) begin
						s_next.tone_ctrl_reg = s_reg.wdata[7:3];
					end
				end
				default: begin
					s_next.bresp = RESP_SLVERR;
				end
			endcase
		end else if (s_reg.wr_state == WR_RESP && i_s_axi_bready) begin
			s_next.wr_state = WR_IDLE;
		end

		if (i_s_axi_arvalid && o_s_axi_arready) begin
			s_next.rd_state = RD_DATA;
			s_next.rresp    = RESP_OKAY;
			case (i_s_axi_araddr[7:2])
				ROW_PITCH_IDX: s_next.rdata = {3'h0, s_reg.row_pitch_reg};
				COL_PITCH_IDX: s_next.rdata = {3'h0, s_reg.column_pitch_reg};
				TONE_CTRL_IDX: s_next.rdata = {s_reg.tone_ctrl_reg, 3'h0};
				default: begin
					s_next.rdata = 8'h00;
					s_next.rresp = RESP_SLVERR;
				end
			endcase
		end else if (s_reg.rd_state == RD_DATA && i_s_axi_rready) begin
			s_next.rd_state = RD_IDLE;
		end

		// Fractional accumulator makes the generator clock tick; the jitter of
		// one system cycle is far below one sample step.
		// Generator clock tick.
		s_next.gen_tick = 1'b0;
		if (!i_stop) begin
			if (acc_sum >= {1'b0, ACC_MOD}) begin
				s_next.acc      = 12'(acc_sum - {1'b0, ACC_MOD});
				s_next.gen_tick = 1'b1;
			end else begin
				s_next.acc = acc_sum[11:0];
			end
		end

		if (illegal) begin
			s_next.mixed = MID_SUPPLY;
		end else if (mode == MODE_SQUARE3) begin
			s_next.mixed = {1'b0, col_if.level} + {1'b0, HALF_LEVEL};
		end else begin
			s_next.mixed = {1'b0, row_if.level} + {1'b0, col_if.level};
		end

		s_next.mixed_oe = out_en && !i_stop;

		if (i_stop || illegal || mode == MODE_SINE || mode == MODE_SQUARE1) begin
			s_next.pacifier = 1'b1;
		end else begin
			s_next.pacifier = row_if.level[5];
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			s_reg <= '{row_pitch_reg: PITCH_RST, column_pitch_reg: PITCH_RST,
				tone_ctrl_reg: CTRL_RST, wr_state: WR_IDLE, aw_held: 1'b0,
				aw_idx: 6'h00, w_held: 1'b0, wdata: 8'h00, wlane0: 1'b0,
				bresp: RESP_OKAY, rd_state: RD_IDLE, rdata: 8'h00, rresp: RESP_OKAY,
				acc: 12'h000, gen_tick: 1'b0, mixed: MID_SUPPLY, mixed_oe: 1'b0,
				pacifier: 1'b1};
		end else begin
			s_reg <= s_next;
		end
	end

	dtmg_tone_path u_row_path (
		.i_clock (i_clock),
		.i_rst_n (i_rst_n),
		.p       (row_if.path)
	);

	dtmg_tone_path u_col_path (
		.i_clock (i_clock),
		.i_rst_n (i_rst_n),
		.p       (col_if.path)
	);

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	sequence ctrl_write_s;
		s_reg.wr_state == WR_IDLE && s_reg.aw_held && s_reg.w_held
			&& s_reg.aw_idx == TONE_CTRL_IDX && s_reg.wlane0;
	endsequence

	sequence paths_idle_s;
		(!row_on && !col_on && out_en && !i_stop)[*3];
	endsequence

	ctrl_write_a: assert property (ctrl_write_s |=> s_reg.tone_ctrl_reg == $past(s_reg.wdata[7:3])
		##0 o_s_axi_bvalid)
		else $error("Control write not stored or not answered.");
	ctrl_read_a: assert property (i_s_axi_arvalid && o_s_axi_arready
		&& i_s_axi_araddr[7:2] == TONE_CTRL_IDX |=> o_s_axi_rvalid && o_s_axi_rdata[2:0] == 3'h0)
		else $error("Control read shows nonzero low bits.");
	illegal_pac_a: assert property (illegal |=> o_pacifier_out)
		else $error("Pacifier not high under illegal code.");
	illegal_mid_a: assert property (illegal && out_en && !i_stop
		|=> o_mixed_tone_out == MID_SUPPLY && o_mixed_tone_oe)
		else $error("Mixed output not at mid level under illegal code.");
	out_enable_a: assert property (!out_en |=> !o_mixed_tone_oe)
		else $error("Mixed output driven while enable clear.");
	stop_hold_a: assert property (i_stop |=> o_pacifier_out && !o_mixed_tone_oe)
		else $error("Stop did not park the outputs.");
	idle_dc_a: assert property (paths_idle_s |=> o_mixed_tone_out == MID_SUPPLY)
		else $error("Idle paths did not give half level.");
	sine_pac_a: assert property (mode[1] == 1'b0 |=> o_pacifier_out)
		else $error("Pacifier toggled in sine or square one mode.");
	sq3_mix_a: assert property (mode == MODE_SQUARE3 && !illegal
		|=> o_mixed_tone_out == {1'b0, $past(col_if.level)} + {1'b0, HALF_LEVEL})
		else $error("Square three mixed output is not the column tone.");

endmodule : dtmg_top
`default_nettype wire

// ===== pkg/dtmg_pkg.sv
// Shared constants, register map and state types of the tone generator.
// Assumes a 25 MHz system clock and an AXI4-Lite master with 32-bit data.
package dtmg_pkg;

	// Clock rates; the generator clock is half the 3.58 MHz oscillator.
	localparam int unsigned SYS_CLK_HZ  = 25000000;
	localparam int unsigned GEN_CLK_HZ  = 3580000 / 2;
	localparam int unsigned ACC_SCALE   = 10000;
	localparam logic [11:0] ACC_STEP    = 12'(GEN_CLK_HZ / ACC_SCALE);
	localparam logic [11:0] ACC_MOD     = 12'(SYS_CLK_HZ / ACC_SCALE);

	// Register indices as printed; the byte address is four times the index.
	localparam logic [5:0] ROW_PITCH_IDX  = 6'h0D;
	localparam logic [5:0] COL_PITCH_IDX  = 6'h0E;
	localparam logic [5:0] TONE_CTRL_IDX  = 6'h0F;

	// Reset values of the register bits that are implemented.
	localparam logic [4:0] PITCH_RST      = 5'h00;
	localparam logic [4:0] CTRL_RST       = 5'h00;

	// Field positions inside the stored tone control bits 7:3.
	localparam int unsigned WAVE_HI_POS   = 4;
	localparam int unsigned WAVE_LO_POS   = 3;
	localparam int unsigned ROW_ON_POS    = 2;
	localparam int unsigned COL_ON_POS    = 1;
	localparam int unsigned OUT_EN_POS    = 0;

	// Waveform modes.
	localparam logic [1:0] MODE_SINE      = 2'h0;
	localparam logic [1:0] MODE_SQUARE1   = 2'h1;
	localparam logic [1:0] MODE_SQUARE2   = 2'h2;
	localparam logic [1:0] MODE_SQUARE3   = 2'h3;

	// Sine scanner and ladder levels.
	localparam logic [4:0] SCAN_LAST     = 5'h1B;
	localparam logic [5:0] MSB_MASK      = 6'h20;
	localparam logic [5:0] HALF_LEVEL    = 6'h20;
	localparam logic [6:0] MID_SUPPLY    = 7'h40;

	localparam logic [1:0] RESP_OKAY     = 2'h0;
	localparam logic [1:0] RESP_SLVERR   = 2'h2;

	typedef enum logic [1:0] {
		WR_IDLE = 2'h0,
		WR_RESP = 2'h1
	} dtmg_wr_e;

	typedef enum logic [1:0] {
		RD_IDLE = 2'h0,
		RD_DATA = 2'h1
	} dtmg_rd_e;

endpackage : dtmg_pkg

// ===== pkg/dtmg_path_if.sv
// Connection between the control logic and one tone path.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface dtmg_path_if;
	logic       run;
	logic       square;
	logic       gen_tick;
	logic [6:0] ratio;
	logic [5:0] level;

	modport ctrl (output run, output square, output gen_tick, output ratio, input level);
	modport path (input run, input square, input gen_tick, input ratio, output level);
endinterface : dtmg_path_if
`default_nettype wire

// ===== verilog/dtmg_tone_path.sv
// One tone path: sample-rate divider, 28-step scanner and sine level table.
// Assumes gen_tick is a one-cycle pulse at the generator clock rate.
`timescale 1ns/1ns
`default_nettype none
module dtmg_tone_path
	import dtmg_pkg::*;
(
	input  wire logic  i_clock,
	input  wire logic  i_rst_n,
	dtmg_path_if.path  p
);

	typedef struct packed {
		logic [6:0] div_cnt;
		logic [4:0] scan;
		logic [5:0] level;
	} dtmg_path_s;

	dtmg_path_s s_reg;
	dtmg_path_s s_next;

	// Entry zero is the dc level, so a held path sits at mid scale.
	function automatic logic [5:0] sine_table(input logic [4:0] idx);
		logic [5:0] v;
		v = 6'h20;
		case (idx)
			5'h00: v = 6'h20;
			5'h01: v = 6'h27;
			5'h02: v = 6'h2D;
			5'h03: v = 6'h33;
			5'h04: v = 6'h38;
			5'h05: v = 6'h3C;
			5'h06: v = 6'h3E;
			5'h07: v = 6'h3F;
			5'h08: v = 6'h3E;
			5'h09: v = 6'h3C;
			5'h0A: v = 6'h38;
			5'h0B: v = 6'h33;
			5'h0C: v = 6'h2D;
			5'h0D: v = 6'h27;
			5'h0E: v = 6'h20;
			5'h0F: v = 6'h19;
			5'h10: v = 6'h13;
			5'h11: v = 6'h0D;
			5'h12: v = 6'h08;
			5'h13: v = 6'h04;
			5'h14: v = 6'h02;
			5'h15: v = 6'h01;
			5'h16: v = 6'h02;
			5'h17: v = 6'h04;
			5'h18: v = 6'h08;
			5'h19: v = 6'h0D;
			5'h1A: v = 6'h13;
			5'h1B: v = 6'h19;
			default: v = 6'h20;
		endcase
		return v;
	endfunction : sine_table

	always_comb begin
		s_next = s_reg;
		if (!p.run) begin
			s_next.div_cnt = 7'h00;
			s_next.scan    = 5'h00;
		end else if (p.gen_tick) begin
			if (s_reg.div_cnt >= p.ratio - 7'h01) begin
				s_next.div_cnt = 7'h00;
				s_next.scan = (s_reg.scan == SCAN_LAST) ? 5'h00 : s_reg.scan + 5'h01;
			end else begin
				s_next.div_cnt = s_reg.div_cnt + 7'h01;
			end
		end
		s_next.level = p.square ? (sine_table(s_reg.scan) & MSB_MASK) : sine_table(s_reg.scan);
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			s_reg <= '{div_cnt: 7'h00, scan: 5'h00, level: HALF_LEVEL};
		end else begin
			s_reg <= s_next;
		end
	end

	assign p.level = s_reg.level;

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	hold_in_reset_a: assert property (!p.run |=> s_reg.div_cnt == 7'h00 && s_reg.scan == 5'h00)
		else $error("Idle path counters are not held at reset state.");
	scan_range_a: assert property (s_reg.scan <= SCAN_LAST)
		else $error("Scanner left its 28-step range.");
	div_wrap_a: assert property (p.run && p.gen_tick && s_reg.div_cnt == p.ratio - 7'h01 && s_reg.scan != SCAN_LAST
		|=> s_reg.div_cnt == 7'h00 && s_reg.scan == $past(s_reg.scan) + 5'h01)
		else $error("Divider wrap did not advance the scanner by one.");

endmodule : dtmg_tone_path
`default_nettype wire

// ===== test/dtmg_listener.sv
// Far-side model of the loudspeaker: times the pacifier square wave.
// Assumes the pacifier pin is a clean logic level on the system clock.
`timescale 1ns/1ns
`default_nettype none
module dtmg_listener (
	input  wire logic i_clock,
	input  wire logic i_pacifier,
	output var int    o_period,
	output var int    o_rises
);
	int   count = 0;
	logic last  = 1'b1;

	initial begin
		o_period = 0;
		o_rises = 0;
	end

	// Period counted between rising edges; last starts high like the idle pin.
	always @(posedge i_clock) begin
		count <= count + 1;
		last <= i_pacifier;
		if (i_pacifier === 1'b1 && last === 1'b0) begin
			o_period <= count + 1;
			o_rises <= o_rises + 1;
			count <= 0;
		end
	end
endmodule : dtmg_listener
`default_nettype wire

// ===== test/tb_dtmg_top.sv
// Testbench of the tone generator: AXI4-Lite register tasks and tone checks.
// Assumes the listener model times the pacifier pin on the same clock.
`timescale 1ns/1ns
`default_nettype none
module tb_dtmg_top;
	import dtmg_pkg::*;

	logic        i_clock;
	logic        i_rst_n;
	logic        stop;
	logic [7:0]  awaddr, araddr;
	logic [3:0]  wstrb;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [1:0]  bresp, rresp, resp;
	logic [31:0] wdata, rdata, rdat;
	logic [6:0]  mixed, mn, mx;
	logic [4:0]  lo_or;
	logic        oe, pac, pac_lo;
	int          period, rises, err_total, compares, i, r0;
	real         f;
	logic [7:0]  row_tab [4] = '{8'h10, 8'h1F, 8'h00, 8'h1F};
	logic [7:0]  col_tab [4] = '{8'h1E, 8'h03, 8'h13, 8'h1E};

	dtmg_top dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_stop(stop),
		.i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
		.i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
		.o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
		.i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
		.o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
		.o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .o_mixed_tone_out(mixed),
		.o_mixed_tone_oe(oe), .o_pacifier_out(pac));

	dtmg_listener far (.i_clock(i_clock), .i_pacifier(pac), .o_period(period),
		.o_rises(rises));

	initial begin
		i_clock = 1'b0;
		forever #20 i_clock = ~i_clock;
	end

	function automatic logic [7:0] ra(input logic [5:0] idx);
		return {idx, 2'b00};
	endfunction : ra

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// Readies are judged at the falling edge, settled for the next rise.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_go, w_go, done;
		@(posedge i_clock);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		done = 1'b0;
		while (!done) begin
			@(negedge i_clock);
			aw_go = awvalid && (awready === 1'b1);
			w_go = wvalid && (wready === 1'b1);
			done = bready && (bvalid === 1'b1);
			if (done) resp = bresp;
			@(posedge i_clock);
			if (aw_go) awvalid <= 1'b0;
			if (w_go) wvalid <= 1'b0;
			if (done) bready <= 1'b0;
		end
	endtask : wr

	task automatic rd(input logic [7:0] a);
		logic ar_go, done;
		@(posedge i_clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		done = 1'b0;
		while (!done) begin
			@(negedge i_clock);
			ar_go = arvalid && (arready === 1'b1);
			done = rready && (rvalid === 1'b1);
			if (done) begin
				rdat = rdata;
				resp = rresp;
			end
			@(posedge i_clock);
			if (ar_go) arvalid <= 1'b0;
			if (done) rready <= 1'b0;
		end
	endtask : rd

	// Records the mixed level range and any pacifier low.
	task automatic watch(input int n);
		repeat (4) @(negedge i_clock);
		mn = 7'h7F;
		mx = 7'h00;
		lo_or = 5'h00;
		pac_lo = 1'b0;
		repeat (n) begin
			@(negedge i_clock);
			if (mixed < mn) mn = mixed;
			if (mixed > mx) mx = mixed;
			lo_or = lo_or | mixed[4:0];
			if (pac !== 1'b1) pac_lo = 1'b1;
		end
	endtask : watch

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : close_out

	initial begin
		repeat (95000) @(posedge i_clock);
		err_total++;
		close_out();
	end

	initial begin
		err_total = 0;
		compares = 0;
		i_rst_n = 1'b0;
		{stop, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata, wstrb} = 52'h0;
		repeat (12) @(posedge i_clock);
		i_rst_n <= 1'b1;
		@(negedge i_clock);
		chk("oe after reset", 32'h0, 32'(oe));
		chk("pacifier idle", 32'h1, 32'(pac));
		for (i = 0; i < 3; i++) begin
			rd(ra(ROW_PITCH_IDX + 6'(i)));
			chk("reset value", 32'h0, rdat);
		end
		wr(ra(ROW_PITCH_IDX), 32'h000000FF);
		rd(ra(ROW_PITCH_IDX));
		chk("row pitch bits", 32'h0000001F, rdat);
		wr(ra(TONE_CTRL_IDX), 32'h000000FF);
		rd(ra(TONE_CTRL_IDX));
		chk("tone ctrl bits", 32'h000000F8, rdat);
		rd(8'h00);
		chk("unmapped read resp", 32'h2, 32'(resp));
		wr(8'h04, 32'h000000FF);
		chk("unmapped write resp", 32'h2, 32'(resp));
		wr(ra(COL_PITCH_IDX), 32'h0000001E);
		wr(ra(TONE_CTRL_IDX), 32'h00000008);
		watch(2000);
		chk("oe on", 32'h1, 32'(oe));
		chk("paths off low", 32'h40, 32'(mn));
		chk("paths off high", 32'h40, 32'(mx));
		for (i = 0; i < 4; i++) begin
			wr(ra(TONE_CTRL_IDX), 32'h00000008);
			wr(ra(ROW_PITCH_IDX), 32'(row_tab[i]));
			wr(ra(COL_PITCH_IDX), 32'(col_tab[i]));
			wr(ra(TONE_CTRL_IDX), 32'h00000038);
			watch(6000);
			if (i >= 2) begin
				chk("legal code moves", 32'h1, 32'(mn !== mx));
			end else begin
				chk("illegal low", 32'h40, 32'(mn));
				chk("illegal high", 32'h40, 32'(mx));
				chk("illegal pacifier", 32'h0, 32'(pac_lo));
			end
		end
		chk("sine pacifier", 32'h0, 32'(pac_lo));
		chk("sine fine steps", 32'h1, 32'(lo_or !== 5'h00));
		wr(ra(TONE_CTRL_IDX), 32'h00000058);
		watch(12000);
		chk("square one pacifier", 32'h0, 32'(pac_lo));
		chk("column only low", 32'h20, 32'(mn));
		chk("square high", 32'h40, 32'(mx));
		chk("square masked", 32'h0, 32'(lo_or));
		wr(ra(TONE_CTRL_IDX), 32'h00000008);
		r0 = rises;
		wr(ra(TONE_CTRL_IDX), 32'h000000B8);
		while (rises < r0 + 2) @(posedge i_clock);
		f = real'(SYS_CLK_HZ) / real'(period);
		chk("tone frequency", 32'h1, 32'(f > 2343.7 && f < 2391.1));
		f = 28.0 * $floor(real'(GEN_CLK_HZ) / (28.0 * 2367.4) + 0.5);
		f = f * real'(SYS_CLK_HZ) / real'(GEN_CLK_HZ);
		chk("divider ratio", 32'h1, 32'(period > f - 30.0 && period < f + 30.0));
		wr(ra(TONE_CTRL_IDX), 32'h000000F8);
		watch(12000);
		chk("square three low", 32'h20, 32'(mn));
		chk("square three high", 32'h40, 32'(mx));
		chk("square three pacifier", 32'h1, 32'(pac_lo));
		@(posedge i_clock);
		stop <= 1'b1;
		watch(6000);
		chk("stop oe", 32'h0, 32'(oe));
		chk("stop pacifier", 32'h0, 32'(pac_lo));
		@(posedge i_clock);
		stop <= 1'b0;
		close_out();
	end
endmodule : tb_dtmg_top
`default_nettype wire
